/* File: include/frc_pkg.sv */
// frc_pkg: constants of the filterless rate upconverter
// assumes: one 50 MHz clock, AXI4-Lite register access, word index times four is the byte address
// Operation
// - take 24-bit stereo DAC samples, emit faster
// - run only while enable bit 12 set
// - rate field bits 11:0 sets output spacing
// - one pair every 2*(rate+1) clock cycles
// - each stored output pair raises interrupt request
// - full flags 13/14 set on update, clear on read of that side's high word
// - overrun bit 15 when update finds full set
// - output valid after 19 DAC interrupts
// - high word bits 23:8, low byte separate
// - config and data registers reset to zero
package frc_pkg;

  // bus geometry
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int SAMPLE_W = 24;

  // register indices, byte address is index times four
  localparam logic [15:0] IDX_CONFIG = 16'hFEC6;
  localparam logic [15:0] IDX_LEFT_LOW = 16'hFEC7;
  localparam logic [15:0] IDX_LEFT_HIGH = 16'hFED8;
  localparam logic [15:0] IDX_RIGHT_LOW = 16'hFED9;
  localparam logic [15:0] IDX_RIGHT_HIGH = 16'hFEDA;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hFEE0;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hFEE1;

  // config field layout
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 12;
  localparam int ENABLE_BIT = 12;
  localparam int LEFT_FULL_BIT = 13;
  localparam int RIGHT_FULL_BIT = 14;
  localparam int OVERRUN_BIT = 15;

  // interrupt status layout
  localparam int IRQ_W = 2;
  localparam int IRQ_PAIR_BIT = 0;
  localparam int IRQ_OVERRUN_BIT = 1;

  // reset values
  localparam logic [REG_W-1:0] CONFIG_RESET = 16'h0000;
  localparam logic [REG_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // timing counts
  localparam int WARMUP_W = 5;
  localparam logic [WARMUP_W-1:0] WARMUP_DAC_IRQS = 5'h13;
  localparam int PERIOD_W = 13;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : frc_pkg

/* File: design/frc_rate_tick.sv */
// frc_rate_tick: output sample pacing divider
// assumes: rate field held stable by software while running
`timescale 1ns/100ps
module frc_rate_tick (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // control
  input wire logic enable_in,
  input wire logic [frc_pkg::RATE_W-1:0] rate_in,
  // pacing pulse
  output logic tick_out
);

  logic [frc_pkg::PERIOD_W-1:0] count;
  logic [frc_pkg::PERIOD_W-1:0] reload;

  // period 2*(rate+1) cycles, so reload at 2*rate+1
  assign reload = {rate_in, 1'b1};

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      count <= '0;
      tick_out <= 1'b0;
    end else if (!enable_in) begin
      // held at zero so the first pair waits a full period
      count <= '0;
      tick_out <= 1'b0;
    end else if (count == reload) begin
      count <= '0;
      tick_out <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick_out <= 1'b0;
    end
  end

endmodule : frc_rate_tick

/* File: design/frc_warmup.sv */
// frc_warmup: start-up delay line fill tracker
// assumes: dac strobe is a one-cycle pulse per input sample pair
`timescale 1ns/100ps
module frc_warmup (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // control
  input wire logic enable_in,
  input wire logic dac_strobe_in,
  // status
  output logic valid_out
);

  logic [frc_pkg::WARMUP_W-1:0] seen;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      seen <= '0;
      valid_out <= 1'b0;
    end else if (!enable_in) begin
      // restart after every disable, the delay line refills
      seen <= '0;
      valid_out <= 1'b0;
    end else if (dac_strobe_in && !valid_out) begin
      seen <= seen + 1'b1;
      valid_out <= (seen + 1'b1 == frc_pkg::WARMUP_DAC_IRQS);
    end
  end

endmodule : frc_warmup

/* File: design/frc_top.sv */
// frc_top: filterless rate upconverter with AXI4-Lite registers
// assumes: dac sample and strobe synchronous to clock_in, one bus master
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
module frc_top (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // dac sample tap
  input wire logic [frc_pkg::SAMPLE_W-1:0] dac_left_in,
  input wire logic [frc_pkg::SAMPLE_W-1:0] dac_right_in,
  input wire logic dac_strobe_in,
  // axi write address
  input wire logic [frc_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic [2:0] s_axi_awprot_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // axi write data
  input wire logic [frc_pkg::DATA_W-1:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // axi write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi read address
  input wire logic [frc_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic [2:0] s_axi_arprot_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // axi read data
  output logic [frc_pkg::DATA_W-1:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // interrupt
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  // register contents
  logic [frc_pkg::RATE_W-1:0] output_rate_field;
  logic converter_enable;
  logic left_full_flag;
  logic right_full_flag;
  logic overrun_flag;
  logic [frc_pkg::REG_W-1:0] left_low_byte;
  logic [frc_pkg::REG_W-1:0] left_high_word;
  logic [frc_pkg::REG_W-1:0] right_low_byte;
  logic [frc_pkg::REG_W-1:0] right_high_word;
  logic [frc_pkg::IRQ_W-1:0] irq_status;
  logic [frc_pkg::IRQ_W-1:0] irq_mask;

  // sample path
  logic [frc_pkg::SAMPLE_W-1:0] hold_left;
  logic [frc_pkg::SAMPLE_W-1:0] hold_right;
  logic tick;
  logic warm;
  logic update;

  // write channel capture
  logic aw_held;
  logic w_held;
  logic [frc_pkg::ADDR_W-1:0] aw_addr;
  logic [frc_pkg::DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [15:0] w_index;
  logic w_hit;
  logic [frc_pkg::REG_W-1:0] w_val;

  // read channel
  logic do_read;
  logic [15:0] r_index;
  logic r_hit;
  logic [frc_pkg::REG_W-1:0] r_val;
  logic read_left;
  logic read_right;

  // write decode strobes
  logic wr_config;
  logic wr_left_low;
  logic wr_left_high;
  logic wr_right_low;
  logic wr_right_high;
  logic wr_status;
  logic wr_mask;

  ////////////////////////////////////////////////////////////////////////////////
  // pacing and start-up

  frc_rate_tick u_rate_tick (
    .clock_in (clock_in),
    .rst_in (rst_in),
    .enable_in (converter_enable),
    .rate_in (output_rate_field),
    .tick_out (tick)
  );

  frc_warmup u_warmup (
    .clock_in (clock_in),
    .rst_in (rst_in),
    .enable_in (converter_enable),
    .dac_strobe_in (dac_strobe_in),
    .valid_out (warm)
  );

  // no output pair until the delay line has filled
  assign update = tick && warm && converter_enable;

  ////////////////////////////////////////////////////////////////////////////////
  // sample hold, filterless: last input pair is repeated at the output rate

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      hold_left <= '0;
      hold_right <= '0;
    end else if (dac_strobe_in) begin
      hold_left <= dac_left_in;
      hold_right <= dac_right_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order

  assign do_write = aw_held && w_held && !s_axi_bvalid_out;
  assign w_index = aw_addr[frc_pkg::ADDR_W-1:2];
  assign w_val = w_data[frc_pkg::REG_W-1:0];

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      s_axi_awready_out <= 1'b1;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_in;
      s_axi_awready_out <= 1'b0;
    end else if (do_write) begin
      aw_held <= 1'b0;
      s_axi_awready_out <= 1'b1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_wready_out <= 1'b1;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_in;
      w_strb <= s_axi_wstrb_in;
      s_axi_wready_out <= 1'b0;
    end else if (do_write) begin
      w_held <= 1'b0;
      s_axi_wready_out <= 1'b1;
    end
  end

  always_comb begin
    wr_config = 1'b0;
    wr_left_low = 1'b0;
    wr_left_high = 1'b0;
    wr_right_low = 1'b0;
    wr_right_high = 1'b0;
    wr_status = 1'b0;
    wr_mask = 1'b0;
    w_hit = 1'b1;
    unique case (w_index)
      frc_pkg::IDX_CONFIG: wr_config = do_write;
      frc_pkg::IDX_LEFT_LOW: wr_left_low = do_write;
      frc_pkg::IDX_LEFT_HIGH: wr_left_high = do_write;
      frc_pkg::IDX_RIGHT_LOW: wr_right_low = do_write;
      frc_pkg::IDX_RIGHT_HIGH: wr_right_high = do_write;
      frc_pkg::IDX_IRQ_STATUS: wr_status = do_write;
      frc_pkg::IDX_IRQ_MASK: wr_mask = do_write;
      default: w_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= frc_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= w_hit ? frc_pkg::RESP_OKAY : frc_pkg::RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration register

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      output_rate_field <= frc_pkg::CONFIG_RESET[frc_pkg::RATE_W-1:0];
      converter_enable <= frc_pkg::CONFIG_RESET[frc_pkg::ENABLE_BIT];
    end else if (wr_config) begin
      if (w_strb[0]) begin
        output_rate_field[7:0] <= w_val[7:0];
      end
      if (w_strb[1]) begin
        output_rate_field[frc_pkg::RATE_W-1:8] <= w_val[frc_pkg::RATE_W-1:8];
        converter_enable <= w_val[frc_pkg::ENABLE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // full and overrun flags; a new pair wins over a read in the same cycle

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      left_full_flag <= frc_pkg::CONFIG_RESET[frc_pkg::LEFT_FULL_BIT];
      right_full_flag <= frc_pkg::CONFIG_RESET[frc_pkg::RIGHT_FULL_BIT];
    end else begin
      if (update) begin
        left_full_flag <= 1'b1;
      end else if (read_left) begin
        left_full_flag <= 1'b0;
      end
      if (update) begin
        right_full_flag <= 1'b1;
      end else if (read_right) begin
        right_full_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      overrun_flag <= frc_pkg::CONFIG_RESET[frc_pkg::OVERRUN_BIT];
    end else if (update && (left_full_flag || right_full_flag)) begin
      overrun_flag <= 1'b1;
    end else if (wr_config && w_strb[1] && w_val[frc_pkg::OVERRUN_BIT]) begin
      // write one to clear, otherwise it would stick forever
      overrun_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output data registers

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      left_low_byte <= frc_pkg::DATA_RESET;
      left_high_word <= frc_pkg::DATA_RESET;
      right_low_byte <= frc_pkg::DATA_RESET;
      right_high_word <= frc_pkg::DATA_RESET;
    end else if (update) begin
      left_high_word <= hold_left[23:8];
      left_low_byte <= {hold_left[7:0], 8'h00};
      right_high_word <= hold_right[23:8];
      right_low_byte <= {hold_right[7:0], 8'h00};
    end else begin
      // software may also write, the hardware pair wins on collision
      if (wr_left_low && w_strb[1]) begin
        left_low_byte[15:8] <= w_val[15:8];
      end
      if (wr_left_high) begin
        if (w_strb[0]) begin
          left_high_word[7:0] <= w_val[7:0];
        end
        if (w_strb[1]) begin
          left_high_word[15:8] <= w_val[15:8];
        end
      end
      if (wr_right_low && w_strb[1]) begin
        right_low_byte[15:8] <= w_val[15:8];
      end
      if (wr_right_high) begin
        if (w_strb[0]) begin
          right_high_word[7:0] <= w_val[7:0];
        end
        if (w_strb[1]) begin
          right_high_word[15:8] <= w_val[15:8];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask; set wins over the write-one clear

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      irq_status <= frc_pkg::IRQ_RESET;
    end else begin
      if (update) begin
        irq_status[frc_pkg::IRQ_PAIR_BIT] <= 1'b1;
      end else if (wr_status && w_strb[0] && w_val[frc_pkg::IRQ_PAIR_BIT]) begin
        irq_status[frc_pkg::IRQ_PAIR_BIT] <= 1'b0;
      end
      if (update && (left_full_flag || right_full_flag)) begin
        irq_status[frc_pkg::IRQ_OVERRUN_BIT] <= 1'b1;
      end else if (wr_status && w_strb[0] && w_val[frc_pkg::IRQ_OVERRUN_BIT]) begin
        irq_status[frc_pkg::IRQ_OVERRUN_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      irq_mask <= frc_pkg::IRQ_RESET;
    end else if (wr_mask && w_strb[0]) begin
      irq_mask <= w_val[frc_pkg::IRQ_W-1:0];
    end
  end

  // registered, so the line trails the status bit by one cycle
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read channel: one read under way, answer one cycle after the address

  assign do_read = s_axi_arvalid_in && s_axi_arready_out;
  assign r_index = s_axi_araddr_in[frc_pkg::ADDR_W-1:2];
  assign read_left = do_read && (r_index == frc_pkg::IDX_LEFT_HIGH);
  assign read_right = do_read && (r_index == frc_pkg::IDX_RIGHT_HIGH);

  always_comb begin
    r_val = '0;
    r_hit = 1'b1;
    unique case (r_index)
      frc_pkg::IDX_CONFIG: r_val = {overrun_flag, right_full_flag, left_full_flag,
                                    converter_enable, output_rate_field};
      frc_pkg::IDX_LEFT_LOW: r_val = left_low_byte;
      frc_pkg::IDX_LEFT_HIGH: r_val = left_high_word;
      frc_pkg::IDX_RIGHT_LOW: r_val = right_low_byte;
      frc_pkg::IDX_RIGHT_HIGH: r_val = right_high_word;
      frc_pkg::IDX_IRQ_STATUS: r_val = {{(frc_pkg::REG_W-frc_pkg::IRQ_W){1'b0}}, irq_status};
      frc_pkg::IDX_IRQ_MASK: r_val = {{(frc_pkg::REG_W-frc_pkg::IRQ_W){1'b0}}, irq_mask};
      default: r_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= '0;
      s_axi_rresp_out <= frc_pkg::RESP_OKAY;
    end else if (do_read) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= {{(frc_pkg::DATA_W-frc_pkg::REG_W){1'b0}}, r_val};
      s_axi_rresp_out <= r_hit ? frc_pkg::RESP_OKAY : frc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
    end
  end

endmodule : frc_top

/* File: verif/frc_top_props.sv */
// frc_top_props: port checks for the rate upconverter
// assumes: bound to frc_top, one clock domain
`timescale 1ns/100ps
module frc_top_props (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // bus handshakes
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [frc_pkg::DATA_W-1:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // interrupt
  input wire logic irq_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////
  a_read_one_cycle: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  a_read_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
    else $error("read answer dropped");
  a_read_single: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("second read accepted");
  a_upper_zero: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
    s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out)
    else $error("write answer late");
  a_write_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write answer dropped");
  a_error_no_data: assert property (s_axi_rvalid_out && s_axi_rresp_out == frc_pkg::RESP_SLVERR |->
    s_axi_rdata_out == 32'h00000000)
    else $error("error read with data");
  a_reset_quiet: assert property ($fell(rst_in) |-> !irq_out && !s_axi_bvalid_out &&
    s_axi_awready_out && s_axi_arready_out)
    else $error("not idle after reset");
  c_read_error: cover property (s_axi_rvalid_out && s_axi_rresp_out == frc_pkg::RESP_SLVERR);
  c_irq_rise: cover property ($rose(irq_out));
  c_write_done: cover property (s_axi_bvalid_out && s_axi_bready_in);
endmodule : frc_top_props
////////////////////////////////////////////////////////////////////////
bind frc_top frc_top_props u_props (.clock_in, .rst_in, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out,
  .s_axi_rready_in, .irq_out);

/* File: verif/frc_dac_source.sv */
// frc_dac_source: stand-in for the primary dac sample path
// assumes: bench clock, spacing set by the bench
`timescale 1ns/100ps
module frc_dac_source (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // control
  input wire logic run_in,
  input wire logic [7:0] gap_in,
  // sample path
  output logic [23:0] left_out,
  output logic [23:0] right_out,
  output logic strobe_out
);
  logic [7:0] cnt;
  logic [7:0] seq;
  // input spacing kept longer than output spacing, no anti-alias filter behind
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 8'h00;
      seq <= 8'h00;
      strobe_out <= 1'b0;
    end else begin
      strobe_out <= run_in && cnt == gap_in;
      cnt <= (!run_in || cnt == gap_in) ? 8'h00 : cnt + 8'h01;
      seq <= seq + {7'h00, run_in && cnt == gap_in};
    end
  end
  // junk off the strobe, so a late capture shows
  assign left_out = strobe_out ? {seq, ~seq, seq ^ 8'h3C} : ~{seq, ~seq, seq ^ 8'h3C};
  assign right_out = strobe_out ? {~seq, seq, 8'hC3} : {seq, ~seq, 8'h3C};
endmodule : frc_dac_source

/* File: verif/frc_top_tb_top.sv */
// frc_top_tb_top: self-checking bench for the rate upconverter
// assumes: package, design, dac source and checker compiled first
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module frc_top_tb_top;
  localparam logic [15:0] RATE = 16'h001F;
  localparam int PER = 64;
  localparam logic [17:0] A_CFG = {frc_pkg::IDX_CONFIG, 2'b00};
  localparam logic [17:0] A_LL = {frc_pkg::IDX_LEFT_LOW, 2'b00};
  localparam logic [17:0] A_LH = {frc_pkg::IDX_LEFT_HIGH, 2'b00};
  localparam logic [17:0] A_RL = {frc_pkg::IDX_RIGHT_LOW, 2'b00};
  localparam logic [17:0] A_RH = {frc_pkg::IDX_RIGHT_HIGH, 2'b00};
  localparam logic [17:0] A_ST = {frc_pkg::IDX_IRQ_STATUS, 2'b00};
  localparam logic [17:0] A_MK = {frc_pkg::IDX_IRQ_MASK, 2'b00};
  localparam logic [1:0] OK = frc_pkg::RESP_OKAY;
  localparam logic [1:0] ER = frc_pkg::RESP_SLVERR;
  typedef struct packed {logic wr; logic [17:0] a; logic [15:0] w; logic [31:0] e; logic [1:0] r;} frc_row_t;
  frc_row_t rows [0:10] = '{'{1'b0, A_CFG, 16'h0, 32'h0, OK}, '{1'b0, A_LL, 16'h0, 32'h0, OK},
    '{1'b0, A_LH, 16'h0, 32'h0, OK}, '{1'b0, A_RL, 16'h0, 32'h0, OK}, '{1'b0, A_RH, 16'h0, 32'h0, OK},
    '{1'b0, A_ST, 16'h0, 32'h0, OK}, '{1'b0, A_MK, 16'h0, 32'h0, OK}, '{1'b1, A_LH, 16'h1234, 32'h1234, OK},
    '{1'b1, A_CFG, 16'h601F, 32'h001F, OK}, '{1'b1, 18'h00100, 16'hFFFF, 32'h0, ER}, '{1'b1, A_LH, 16'h0, 32'h0, OK}};
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [17:0] awaddr = 18'h0, araddr = 18'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, run = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq_out, strobe;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [23:0] dl, dr, el, er;
  int n_fail = 0, tests_run = 0, n_strobe = 0, cyc = 0;
  always #10 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    // every strobe counts, one can trail the fall of run and the design holds it too
    if (strobe) begin
      n_strobe <= n_strobe + 1;
      el <= dl;
      er <= dr;
    end
  end
  frc_dac_source u_src (.clock_in, .rst_in, .run_in(run), .gap_in(8'd99), .left_out(dl), .right_out(dr),
    .strobe_out(strobe));
  frc_top dut (.clock_in, .rst_in, .dac_left_in(dl), .dac_right_in(dr), .dac_strobe_in(strobe),
    .s_axi_awaddr_in(awaddr), .s_axi_awprot_in(3'h0), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arprot_in(3'h0), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .irq_out);
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic guard(input int k, input int lim);
    if (k >= lim) begin
      n_fail++;
      $display("ERROR %0t wait timed out", $time);
      final_report();
    end
  endtask : guard
  task automatic wr(input logic [17:0] a, input logic [15:0] d, output logic [1:0] r);
    int k;
    @(posedge clock_in);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clock_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    guard(k, 50);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [17:0] a, input logic [31:0] e, input logic [1:0] er);
    int k;
    @(posedge clock_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clock_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    guard(k, 50);
    `CHK(rdata, e)
    `CHK(rresp, er)
    rready <= 1'b0;
  endtask : rchk
  task automatic irq_is(input logic v);
    repeat (2) @(posedge clock_in);
    `CHK(irq_out, v)
  endtask : irq_is
  ////////////////////////////////////////////////////////////////////////
  initial begin
    int k, t1;
    logic [1:0] r;
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].a, rows[i].w, r);
        `CHK(r, rows[i].r)
      end
      rchk(rows[i].a, rows[i].e, rows[i].r);
    end
    $display("test table done");
    wr(A_MK, 16'h0001, r);
    wr(A_CFG, 16'h1000 | RATE, r);
    run <= 1'b1;
    for (k = 0; k < 4000 && n_strobe < 19; k++) begin
      @(posedge clock_in);
      `CHK(irq_out, 1'b0)
    end
    guard(k, 4000);
    for (k = 0; k < PER + 4 && irq_out !== 1'b1; k++) @(posedge clock_in);
    `CHK(irq_out, 1'b1)
    t1 = cyc;
    wr(A_ST, 16'h0003, r);
    for (k = 0; k < PER && irq_out !== 1'b0; k++) @(posedge clock_in);
    for (k = 0; k < PER + 4 && irq_out !== 1'b1; k++) @(posedge clock_in);
    `CHK(32'(cyc - t1), 32'(PER))
    $display("test pacing done");
    run <= 1'b0;
    repeat (2 * PER) @(posedge clock_in);
    wr(A_CFG, RATE, r);
    rchk(A_CFG, 32'h0000E01F, OK);
    rchk(A_LH, {16'h0, el[23:8]}, OK);
    rchk(A_LL, {16'h0, el[7:0], 8'h00}, OK);
    rchk(A_RH, {16'h0, er[23:8]}, OK);
    rchk(A_RL, {16'h0, er[7:0], 8'h00}, OK);
    rchk(A_CFG, 32'h0000801F, OK);
    wr(A_CFG, 16'h8000 | RATE, r);
    rchk(A_CFG, 32'h0000001F, OK);
    rchk(A_ST, 32'h00000003, OK);
    $display("test flags done");
    irq_is(1'b1);
    wr(A_MK, 16'h0000, r);
    irq_is(1'b0);
    wr(A_MK, 16'h0001, r);
    irq_is(1'b1);
    wr(A_ST, 16'h0003, r);
    irq_is(1'b0);
    run <= 1'b1;
    repeat (300) @(posedge clock_in);
    `CHK(irq_out, 1'b0)
    rchk(A_CFG, 32'h0000001F, OK);
    $display("test disabled done");
    wr(A_CFG, 16'h1000 | RATE, r);
    wr(A_LH, 16'h55AA, r);
    rst_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    rchk(A_CFG, 32'h0, OK);
    rchk(A_LH, 32'h0, OK);
    $display("test reset done");
    final_report();
  end
endmodule : frc_top_tb_top
